// ---- bench/flash_model.sv ----
// flash device model: command decode, polling status, ready/busy
// assumes ce_n falls with we_n or oe_n and the host drives dq on writes only
`timescale 1ns/100ps
`default_nettype none
module flash_model
	import flash_host_pkg::*;
#(
	parameter logic [7:0] MAKER_CODE = 8'h3c, // arbitrary
	parameter logic [7:0] PART_CODE  = 8'h5a, // arbitrary
	parameter logic [7:0] QRY_BYTE   = 8'h51,
	parameter int         PROT_GRP   = 7,
	parameter int         PROG_NS    = 2000,
	parameter int         ERASE_NS   = 20000,
	parameter int         WIN_NS     = 1000
) (
	// host side
	input  wire flash_host_pkg::pins_s pins_in,
	// device side
	output logic [7:0]                 dq_out,
	output logic                       ready_busy_n_out,
	output var int                     seq_err_out
);
	typedef enum logic [2:0] {ARR, AUTO, QRY, PROG, ERS, WIN, SUSP} mode_e;
	mode_e       mode  = ARR;
	logic        sus   = 1'b0;
	logic        byp   = 1'b0;
	logic        chip  = 1'b0;
	logic        armed = 1'b0;
	int          step  = 0;
	logic [7:0]  mem [int];
	logic [20:0] a_lat;
	logic [20:0] pa;
	logic [7:0]  pd;
	logic [7:0]  last  = 8'h00;
	logic [31:0] sect;
	realtime     t_end;
	realtime     t_left;
	initial seq_err_out = 0;
	initial ready_busy_n_out = 1'b1;

	task automatic go(input mode_e m, input realtime ns);
		mode  = m;
		t_end = $realtime + ns;
	endtask

	task automatic seq(input logic [20:0] a, input logic [7:0] d);
		logic u1;
		logic u2;
		int   nx;
		u1 = a[10:0] == UNLOCK_ADDR1[10:0];
		u2 = a[10:0] == UNLOCK_ADDR2[10:0];
		nx = 0;
		if (step == 3) begin
			pa = a;
			pd = d;
			go(PROG, PROG_NS);
		end else if (byp && step == 0 && d == D_PROGRAM)
			nx = 3;
		else if (byp && step == 0 && d == D_AUTOSEL)
			nx = 7;
		else if (byp && step == 7 && d == D_BYP_EXIT)
			byp = 1'b0;
		else if (!byp && step == 0 && d == D_RESET)
			mode = sus ? SUSP : ARR;
		else if (!byp && step == 0 && d == D_QUERY && a[10:0] == QUERY_ADDR[10:0] && mode inside {ARR, AUTO})
			mode = QRY;
		else if (!byp && step == 0 && d == D_RESUME && mode == SUSP) begin
			sus = 1'b0;
			go(ERS, t_left);
		end else if (step == 0 && d == D_SUSPEND)
			;
		else if (!byp && (step == 0 || step == 4) && u1 && d == D_UNLOCK1)
			nx = step + 1;
		else if (!byp && (step == 1 || step == 5) && u2 && d == D_UNLOCK2)
			nx = step + 1;
		else if (step == 2 && u1 && d == D_AUTOSEL)
			mode = AUTO;
		else if (step == 2 && u1 && d == D_PROGRAM)
			nx = 3;
		else if (step == 2 && u1 && d == D_BYPASS)
			byp = 1'b1;
		else if (step == 2 && u1 && d == D_ERASE && !sus)
			nx = 4;
		else if (step == 6 && u1 && d == D_CHIP) begin
			chip = 1'b1;
			sect = '1;
			go(ERS, ERASE_NS);
		end else if (step == 6 && d == D_SECTOR) begin
			chip = 1'b0;
			sect = 32'h1 << a[20:16];
			go(WIN, WIN_NS);
		end else
			seq_err_out++;
		step = nx;
	endtask

	task automatic wr(input logic [20:0] a, input logic [7:0] d);
		if (mode inside {ERS, WIN} && d == D_SUSPEND && !chip) begin
			sus    = 1'b1;
			t_left = mode == WIN ? ERASE_NS : t_end - $realtime;
			mode   = SUSP;
		end else if (mode == WIN && d == D_SECTOR) begin
			sect[a[20:16]] = 1'b1;
			go(WIN, WIN_NS);
		end else if (mode == WIN)
			mode = ARR;
		else if (mode != PROG && mode != ERS)
			seq(a, d);
	endtask

	function automatic logic [7:0] rd(input logic [20:0] a);
		logic [7:0] v;
		v = mem.exists(a) ? mem[a] : 8'hff;
		case (mode)
			AUTO: return a[1:0] == 2'h0 ? MAKER_CODE : a[1:0] == 2'h1 ? PART_CODE : {7'h0, a[20:18] == PROT_GRP};
			QRY: return QRY_BYTE;
			PROG: return a == pa ? {~pd[7], 7'h00} : v;
			ERS, WIN: return 8'h00;
			SUSP: return sect[a[20:16]] ? 8'h80 : v;
			default: return v;
		endcase
	endfunction

	// address on the later fall, data on the earlier rise
	always @(negedge pins_in.we_n or negedge pins_in.ce_n)
		if (!pins_in.we_n && !pins_in.ce_n) begin
			a_lat = pins_in.addr;
			armed = 1'b1;
		end
	always @(posedge pins_in.we_n or posedge pins_in.ce_n)
		if (armed) begin
			armed = 1'b0;
			wr(a_lat, pins_in.dq_o);
		end

	// no pull on dq: a released bus shows the inverse of the last byte the flash drove
	always @(pins_in or mode) begin
		if (!pins_in.dq_oe_n)
			dq_out = pins_in.dq_o;
		else if (!pins_in.ce_n && !pins_in.oe_n) begin
			dq_out = rd(pins_in.addr);
			last   = dq_out;
		end else
			dq_out = ~last;
	end

	always #50 begin
		if (mode == WIN && $realtime >= t_end)
			go(ERS, ERASE_NS);
		else if (mode == PROG && $realtime >= t_end) begin
			if (pa[20:18] != PROT_GRP)
				mem[pa] = pd;
			mode = sus ? SUSP : ARR;
		end else if (mode == ERS && $realtime >= t_end) begin
			foreach (mem[k])
				if (sect[k >> 16] && (k >> 18) != PROT_GRP)
					mem[k] = 8'hff;
			mode = ARR;
		end
		ready_busy_n_out = !(mode inside {PROG, ERS, WIN});
	end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// top bench: user orders against the flash model
// assumes one order at a time and a done pulse per order
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import flash_host_pkg::*;
	localparam logic [7:0]  MAKER = 8'h3c; // arbitrary
	localparam logic [7:0]  PART  = 8'h5a; // arbitrary
	localparam logic [20:0] A1    = 21'h012345;
	localparam logic [20:0] A2    = 21'h0a0010;
	localparam logic [20:0] A3    = 21'h050020;
	localparam logic [20:0] AP    = 21'h1c0100;
	logic        core_clk_in     = 1'b0;
	logic        srst_in         = 1'b1;
	logic        order_valid_in  = 1'b0;
	order_s      order_in        = '0;
	logic        order_ready_out;
	logic        done_out;
	logic        fail_out;
	logic        busy_out;
	logic        window_open_out;
	logic        ready_busy_n_in;
	logic [7:0]  rdata_out;
	logic [7:0]  dq_in;
	pins_s       pins_out;
	int          seq_err;
	int          fails           = 0;
	int          cmp_count       = 0;
	int          n;

	always #25 core_clk_in = ~core_clk_in;

	flash_host_ctrl #(.WINDOW_CYC(20)) u_dut (.core_clk_in, .srst_in, .order_valid_in, .order_in,
		.order_ready_out, .done_out, .rdata_out, .fail_out, .busy_out, .window_open_out,
		.dq_in, .ready_busy_n_in, .pins_out);
	flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) u_flash (.pins_in(pins_out), .dq_out(dq_in),
		.ready_busy_n_out(ready_busy_n_in), .seq_err_out(seq_err));

	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	task automatic ord(input op_e op, input logic [20:0] a, input logic [7:0] d);
		int k;
		@(negedge core_clk_in);
		order_valid_in = 1'b1;
		order_in       = '{op, a, d};
		k = 0;
		while (order_ready_out !== 1'b1 && k++ < 400)
			@(negedge core_clk_in);
		@(negedge core_clk_in);
		order_valid_in = 1'b0;
		while (done_out !== 1'b1 && k++ < 400)
			@(negedge core_clk_in);
		if (k >= 400) begin
			fails++;
			$display("unexpected at %0t: order hung", $time);
			give_verdict();
		end
	endtask

	// polls until the poll bit shows its true value; n counts the tries
	task automatic poll(input logic [20:0] a, input logic b7);
		n = 0;
		do begin
			ord(OP_POLL, a, {b7, 7'h00});
			n++;
		end while ((rdata_out[7] !== b7 || fail_out !== 1'b0) && n < 100);
		chk(rdata_out & 8'h80, {b7, 7'h00});
		chk({7'h0, fail_out}, 8'h00);
	endtask

	// 12 cycles of reset plus well under 20000 cycles of orders
	initial begin
		#1_000_000;
		fails++;
		give_verdict();
	end

	initial begin
		repeat (12) @(negedge core_clk_in);
		srst_in = 1'b0;
		repeat (2) @(negedge core_clk_in);
		chk({4'h0, busy_out, pins_out.ce_n, pins_out.we_n, pins_out.dq_oe_n}, 8'h07);
		ord(OP_READ, A1, 8'h00);
		chk(rdata_out, 8'hff);
		ord(OP_AUTOSEL, MAKER_ADDR, 8'h00);
		chk(rdata_out, MAKER);
		ord(OP_READ, PART_ADDR, 8'h00);
		chk(rdata_out, PART);
		ord(OP_READ, PROT_ADDR | 21'h1c0000, 8'h00);
		chk(rdata_out, 8'h01);
		ord(OP_READ, PROT_ADDR | 21'h040000, 8'h00);
		chk(rdata_out, 8'h00);
		ord(OP_QUERY, QUERY_ADDR, 8'h00);
		ord(OP_READ, A1, 8'h00);
		chk(rdata_out, 8'h51);
		ord(OP_RESET, ANY_ADDR, 8'h00);
		ord(OP_READ, A1, 8'h00);
		chk(rdata_out, 8'hff);
		ord(OP_PROGRAM, A1, 8'h3c);
		poll(A1, 1'b0);
		chk({7'h0, n > 1}, 8'h01);
		chk(rdata_out, 8'h3c);
		ord(OP_READ, A1, 8'h00);
		chk(rdata_out, 8'h3c);
		ord(OP_BYPASS, UNLOCK_ADDR1, 8'h00);
		ord(OP_BYP_PROG, A2, 8'ha5);
		poll(A2, 1'b1);
		ord(OP_BYP_EXIT, ANY_ADDR, 8'h00);
		ord(OP_READ, A2, 8'h00);
		chk(rdata_out, 8'ha5);
		ord(OP_PROGRAM, AP, 8'ha5);
		poll(AP, 1'b1);
		ord(OP_READ, AP, 8'h00);
		chk(rdata_out, 8'hff);
		ord(OP_CHIP_ERS, UNLOCK_ADDR1, 8'h00);
		poll(A1, 1'b1);
		chk({7'h0, n > 1}, 8'h01);
		ord(OP_READ, A2, 8'h00);
		chk(rdata_out, 8'hff);
		ord(OP_PROGRAM, A1, 8'h3c);
		poll(A1, 1'b0);
		ord(OP_SECT_ERS, A1, D_SECTOR);
		chk({7'h0, window_open_out}, 8'h01);
		ord(OP_SECT_ADD, A2, D_SECTOR);
		ord(OP_SUSPEND, ANY_ADDR, 8'h00);
		poll(A1, 1'b1);
		chk(n[7:0], 8'h01);
		ord(OP_PROGRAM, A3, 8'h66);
		poll(A3, 1'b0);
		ord(OP_AUTOSEL, MAKER_ADDR, 8'h00);
		chk(rdata_out, MAKER);
		ord(OP_RESET, ANY_ADDR, 8'h00);
		ord(OP_RESUME, ANY_ADDR, 8'h00);
		poll(A2, 1'b1);
		chk({7'h0, n > 1}, 8'h01);
		ord(OP_READ, A1, 8'h00);
		chk(rdata_out, 8'hff);
		ord(OP_READ, A3, 8'h00);
		chk(rdata_out, 8'h66);
		chk(seq_err[7:0], 8'h00);
		give_verdict();
	end
endmodule
`default_nettype wire

// ---- common/flash_host_pkg.sv ----
// package for the flash host controller: command codes, addresses, timing
// assumes a byte-wide parallel flash with active-low strobes on the far side
package flash_host_pkg;

	// ****************************************
	// bus layout
	// ****************************************
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;

	// ****************************************
	// unlock and command addresses
	// ****************************************
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR1 = 21'h000555;
	localparam logic [ADDR_W-1:0] UNLOCK_ADDR2 = 21'h0002aa;
	localparam logic [ADDR_W-1:0] QUERY_ADDR   = 21'h000055;
	localparam logic [ADDR_W-1:0] ANY_ADDR     = 21'h000000;
	localparam logic [ADDR_W-1:0] MAKER_ADDR   = 21'h000000;
	localparam logic [ADDR_W-1:0] PART_ADDR    = 21'h000001;
	localparam logic [ADDR_W-1:0] PROT_ADDR    = 21'h000002;
	localparam int               GROUP_LSB    = 18;

	// ****************************************
	// command data
	// ****************************************
	localparam logic [DATA_W-1:0] D_UNLOCK1  = 8'haa;
	localparam logic [DATA_W-1:0] D_UNLOCK2  = 8'h55;
	localparam logic [DATA_W-1:0] D_RESET    = 8'hf0;
	localparam logic [DATA_W-1:0] D_AUTOSEL  = 8'h90;
	localparam logic [DATA_W-1:0] D_QUERY    = 8'h98;
	localparam logic [DATA_W-1:0] D_PROGRAM  = 8'ha0;
	localparam logic [DATA_W-1:0] D_BYPASS   = 8'h20;
	localparam logic [DATA_W-1:0] D_BYP_EXIT = 8'h00;
	localparam logic [DATA_W-1:0] D_ERASE    = 8'h80;
	localparam logic [DATA_W-1:0] D_CHIP     = 8'h10;
	localparam logic [DATA_W-1:0] D_SECTOR   = 8'h30;
	localparam logic [DATA_W-1:0] D_SUSPEND  = 8'hb0;
	localparam logic [DATA_W-1:0] D_RESUME   = 8'h30;

	// ****************************************
	// timing at 20 MHz
	// ****************************************
	localparam int CLK_PERIOD_NS   = 50;
	localparam int PULSE_NS        = 100;
	localparam int PULSE_CYC       = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ERASE_WINDOW_US = 50;
	localparam int ERASE_WINDOW_CYC = ERASE_WINDOW_US * 1000 / CLK_PERIOD_NS;

	// ****************************************
	// user orders
	// ****************************************
	typedef enum logic [3:0] {
		OP_READ     = 4'h0,
		OP_RESET    = 4'h1,
		OP_AUTOSEL  = 4'h2,
		OP_QUERY    = 4'h3,
		OP_PROGRAM  = 4'h4,
		OP_BYPASS   = 4'h5,
		OP_BYP_PROG = 4'h6,
		OP_BYP_EXIT = 4'h7,
		OP_CHIP_ERS = 4'h8,
		OP_SECT_ERS = 4'h9,
		OP_SECT_ADD = 4'ha,
		OP_SUSPEND  = 4'hb,
		OP_RESUME   = 4'hc,
		OP_POLL     = 4'hd
	} op_e;

	typedef struct packed {
		op_e               op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} order_s;

	// one bus cycle as the sequencer hands it to the cycle engine
	typedef struct packed {
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cycle_s;

	// flash pins driven by the host
	typedef struct packed {
		logic              ce_n;
		logic              we_n;
		logic              oe_n;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] dq_o;
		logic              dq_oe_n;
	} pins_s;

endpackage

// ---- verilog/flash_bus_cycle.sv ----
// one flash bus cycle: write or read, strobes held a fixed number of clocks
// assumes the flash answers within the strobe time at the 20 MHz clock
`timescale 1ns/100ps
`default_nettype none
module flash_bus_cycle
	import flash_host_pkg::*;
#(
	parameter int PULSE = PULSE_CYC
) (
	// clock and reset
	input  wire logic                            core_clk_in,
	input  wire logic                            srst_in,
	// request
	input  wire logic                            start_in,
	input  wire flash_host_pkg::cycle_s          cyc_in,
	output logic                                 done_out,
	output logic [flash_host_pkg::DATA_W-1:0]    rdata_out,
	// flash side
	input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
	output flash_host_pkg::pins_s                pins_out
);
	import flash_host_pkg::*;

	typedef struct packed {
		logic              busy;
		logic [3:0]        cnt;
		logic              done;
		logic [DATA_W-1:0] rdata;
		pins_s             pins;
	} st_s;

	st_s st_q;
	st_s st_d;

	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		if (!st_q.busy && start_in) begin
			st_d.busy = 1'b1;
			st_d.cnt = 4'h0;
			st_d.pins.addr = cyc_in.addr;
			st_d.pins.ce_n = 1'b0;
			// read cycles only outside command writes
			st_d.pins.we_n = !cyc_in.wr;
			st_d.pins.oe_n = cyc_in.wr;
			st_d.pins.dq_o = cyc_in.data;
			st_d.pins.dq_oe_n = !cyc_in.wr;
		end else if (st_q.busy) begin
			st_d.cnt = st_q.cnt + 4'h1;
			if (st_q.cnt == 4'(PULSE - 1)) begin
				// data is held past the we_n rise so the flash latches it
				st_d.rdata = dq_in;
				st_d.pins.we_n = 1'b1;
				st_d.pins.oe_n = 1'b1;
				st_d.pins.ce_n = 1'b1;
			end else if (st_q.cnt == 4'(PULSE)) begin
				st_d.busy = 1'b0;
				st_d.done = 1'b1;
				st_d.pins.dq_oe_n = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			st_q <= '{busy: 1'b0, cnt: 4'h0, done: 1'b0, rdata: 8'h00,
				pins: '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 21'h000000,
				dq_o: 8'h00, dq_oe_n: 1'b1}};
		end else begin
			st_q <= st_d;
		end
	end

	assign done_out  = st_q.done;
	assign rdata_out = st_q.rdata;
	assign pins_out  = st_q.pins;

	// ****************************************
	// checks
	// ****************************************
	strobe_excl_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		!(!st_q.pins.we_n && !st_q.pins.oe_n)) else $error("we and oe low together");
	data_hold_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		$rose(st_q.pins.we_n) |-> !st_q.pins.dq_oe_n) else $error("data dropped at we rise");
endmodule
`default_nettype wire

// ---- verilog/flash_host_ctrl.sv ----
// host controller that drives a parallel flash through its pins
// assumes one order at a time on the user port; flash strobes are active low
`timescale 1ns/100ps
`default_nettype none
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter int WINDOW_CYC = ERASE_WINDOW_CYC
) (
	// clock and reset
	input  wire logic                              core_clk_in,
	input  wire logic                              srst_in,
	// user orders
	input  wire logic                              order_valid_in,
	input  wire flash_host_pkg::order_s            order_in,
	output logic                                   order_ready_out,
	output logic                                   done_out,
	output logic [flash_host_pkg::DATA_W-1:0]      rdata_out,
	output logic                                   fail_out,
	output logic                                   busy_out,
	output logic                                   window_open_out,
	// flash pins
	input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
	input  wire logic                              ready_busy_n_in,
	output flash_host_pkg::pins_s                  pins_out
);
	import flash_host_pkg::*;

	// ****************************************
	// state
	// ****************************************
	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_ISSUE = 3'b001,
		S_WAIT  = 3'b010,
		S_FINAL = 3'b011
	} state_e;

	typedef struct packed {
		state_e            state;
		order_s            ord;
		logic [2:0]        idx;
		logic [2:0]        last;
		logic              done;
		logic [DATA_W-1:0] rdata;
		logic              fail;
		logic              bypass;
		logic [15:0]       win;
		logic              ready;
		logic              busy;
		logic              win_open;
	} st_s;

	st_s    st_q;
	st_s    st_d;
	cycle_s cyc;
	logic   cyc_start;
	logic   cyc_done;
	logic [DATA_W-1:0] cyc_rdata;

	// ****************************************
	// cycle table for each order
	// ****************************************
	always_comb begin
		cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_UNLOCK1};
		case (st_q.ord.op)
			OP_READ, OP_POLL: cyc = '{wr: 1'b0, addr: st_q.ord.addr, data: 8'h00};
			OP_RESET:   cyc = '{wr: 1'b1, addr: ANY_ADDR, data: D_RESET};
			OP_QUERY:   cyc = '{wr: 1'b1, addr: QUERY_ADDR, data: D_QUERY};
			OP_SUSPEND: cyc = '{wr: 1'b1, addr: ANY_ADDR, data: D_SUSPEND};
			OP_RESUME:  cyc = '{wr: 1'b1, addr: ANY_ADDR, data: D_RESUME};
			OP_SECT_ADD: cyc = '{wr: 1'b1, addr: st_q.ord.addr, data: D_SECTOR};
			OP_BYP_PROG: begin
				if (st_q.idx == 3'd0)
					cyc = '{wr: 1'b1, addr: ANY_ADDR, data: D_PROGRAM};
				else
					cyc = '{wr: 1'b1, addr: st_q.ord.addr, data: st_q.ord.data};
			end
			OP_BYP_EXIT: begin
				if (st_q.idx == 3'd0)
					cyc = '{wr: 1'b1, addr: ANY_ADDR, data: D_AUTOSEL};
				else
					cyc = '{wr: 1'b1, addr: ANY_ADDR, data: D_BYP_EXIT};
			end
			default: begin
				case (st_q.idx)
					3'd0: cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_UNLOCK1};
					3'd1, 3'd4: cyc = '{wr: 1'b1, addr: UNLOCK_ADDR2, data: D_UNLOCK2};
					3'd2: begin
						case (st_q.ord.op)
							OP_AUTOSEL: cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_AUTOSEL};
							OP_PROGRAM: cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_PROGRAM};
							OP_BYPASS:  cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_BYPASS};
							default:    cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_ERASE};
						endcase
					end
					3'd3: begin
						case (st_q.ord.op)
							// autoselect fourth cycle is a read: X00, X01 or group at X02
							OP_AUTOSEL: cyc = '{wr: 1'b0, addr: st_q.ord.addr, data: 8'h00};
							OP_PROGRAM: cyc = '{wr: 1'b1, addr: st_q.ord.addr, data: st_q.ord.data};
							default:    cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_UNLOCK1};
						endcase
					end
					default: begin
						case (st_q.ord.op)
							OP_CHIP_ERS: cyc = '{wr: 1'b1, addr: UNLOCK_ADDR1, data: D_CHIP};
							default: cyc = '{wr: 1'b1, addr: st_q.ord.addr, data: D_SECTOR};
						endcase
					end
				endcase
			end
		endcase
	end

	function automatic logic [2:0] last_idx(input op_e op);
		case (op)
			OP_AUTOSEL, OP_PROGRAM: last_idx = 3'd3;
			OP_BYPASS:              last_idx = 3'd2;
			OP_BYP_PROG, OP_BYP_EXIT: last_idx = 3'd1;
			OP_CHIP_ERS, OP_SECT_ERS: last_idx = 3'd5;
			default:                last_idx = 3'd0;
		endcase
	endfunction

	assign cyc_start = (st_q.state == S_ISSUE);

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		st_d = st_q;
		st_d.done = 1'b0;
		// window runs on through later orders until a suspend order clears it; the flash timer stops on any write but sector or suspend
		if (st_q.win != 16'h0000)
			st_d.win = st_q.win - 16'h0001;
		case (st_q.state)
			S_IDLE: begin
				st_d.ready = 1'b1;
				if (order_valid_in && st_q.ready) begin
					st_d.ord = order_in;
					st_d.idx = 3'd0;
					st_d.last = last_idx(order_in.op);
					st_d.fail = 1'b0;
					st_d.ready = 1'b0;
					st_d.busy = 1'b1;
					st_d.state = S_ISSUE;
				end
			end
			S_ISSUE: st_d.state = S_WAIT;
			S_WAIT: begin
				if (cyc_done) begin
					// only read cycles carry flash data back
					if (!cyc.wr)
						st_d.rdata = cyc_rdata;
					if (st_q.idx != st_q.last) begin
						st_d.idx = st_q.idx + 3'd1;
						st_d.state = S_ISSUE;
					end else begin
						st_d.state = S_FINAL;
						if (st_q.ord.op == OP_BYPASS) st_d.bypass = 1'b1;
						if (st_q.ord.op == OP_BYP_EXIT || st_q.ord.op == OP_RESET) st_d.bypass = 1'b0;
						if (st_q.ord.op == OP_SECT_ERS || st_q.ord.op == OP_SECT_ADD)
							st_d.win = 16'(WINDOW_CYC);
					end
				end
			end
			S_FINAL: begin
				// poll bit true or fail bit up: one more read, since bits may change apart
				if (st_q.ord.op == OP_POLL && st_q.idx == 3'd0
					&& (st_q.rdata[7] == st_q.ord.data[7] || st_q.rdata[5])) begin
					st_d.idx = 3'd1;
					st_d.last = 3'd1;
					st_d.state = S_ISSUE;
				end else begin
					if (st_q.ord.op == OP_POLL)
						st_d.fail = st_q.rdata[5] && (st_q.rdata[7] != st_q.ord.data[7]);
					st_d.done = 1'b1;
					st_d.busy = 1'b0;
					st_d.state = S_IDLE;
				end
			end
			default: st_d.state = S_IDLE;
		endcase
		if (st_q.ord.op == OP_SUSPEND && st_q.state == S_FINAL)
			st_d.win = 16'h0000;
		st_d.win_open = (st_d.win != 16'h0000);
	end

	always_ff @(posedge core_clk_in) begin
		if (srst_in) begin
			st_q <= '{state: S_IDLE, ord: '{op: OP_READ, addr: 21'h000000, data: 8'h00},
				idx: 3'd0, last: 3'd0, done: 1'b0, rdata: 8'h00, fail: 1'b0,
				bypass: 1'b0, win: 16'h0000, ready: 1'b0, busy: 1'b0, win_open: 1'b0};
		end else begin
			st_q <= st_d;
		end
	end

	flash_bus_cycle #(
		.PULSE (PULSE_CYC)
	) u_cycle (
		.core_clk_in (core_clk_in),
		.srst_in     (srst_in),
		.start_in    (cyc_start),
		.cyc_in      (cyc),
		.done_out    (cyc_done),
		.rdata_out   (cyc_rdata),
		.dq_in       (dq_in),
		.pins_out    (pins_out)
	);

	assign order_ready_out = st_q.ready;
	assign done_out        = st_q.done;
	assign rdata_out       = st_q.rdata;
	assign fail_out        = st_q.fail;
	assign busy_out        = st_q.busy;
	assign window_open_out = st_q.win_open;

	// ****************************************
	// checks
	// ****************************************
	unlock_pair_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		cyc_start && cyc.data == D_UNLOCK1 && cyc.addr == UNLOCK_ADDR1 && st_q.ord.op != OP_READ
		&& st_q.ord.op != OP_POLL && st_q.ord.op != OP_BYP_PROG |=> ##[1:6] cyc_start && cyc.data == D_UNLOCK2)
		else $error("unlock pair broken");
	reset_one_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		cyc_start && st_q.ord.op == OP_RESET |-> cyc.addr == ANY_ADDR && cyc.data == D_RESET && st_q.last == 3'd0)
		else $error("reset not single F0");
	bypass_enter_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		st_q.state == S_WAIT && cyc_done && st_q.ord.op == OP_BYPASS && st_q.idx == st_q.last |=> st_q.bypass)
		else $error("bypass flag not set");
	bypass_exit_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		st_q.state == S_WAIT && cyc_done && st_q.ord.op == OP_BYP_EXIT && st_q.idx == 3'd1 |=> !st_q.bypass)
		else $error("bypass flag not cleared");
	chip_last_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		cyc_start && st_q.ord.op == OP_CHIP_ERS && st_q.idx == 3'd5 |-> cyc.data == D_CHIP && cyc.addr == UNLOCK_ADDR1)
		else $error("chip erase last cycle wrong");
	sector_last_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		cyc_start && st_q.ord.op == OP_SECT_ERS && st_q.idx == 3'd5 |-> cyc.data == D_SECTOR && cyc.addr == st_q.ord.addr)
		else $error("sector erase last cycle wrong");
	query_one_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		cyc_start && st_q.ord.op == OP_QUERY |-> cyc.addr == QUERY_ADDR && cyc.data == D_QUERY)
		else $error("query cycle wrong");
	window_load_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		st_q.state == S_WAIT && cyc_done && st_q.ord.op == OP_SECT_ERS && st_q.idx == 3'd5 |=> st_q.win == 16'(WINDOW_CYC))
		else $error("erase window not loaded");
	prog_data_a: assert property (@(posedge core_clk_in) disable iff (srst_in)
		cyc_start && st_q.ord.op == OP_PROGRAM && st_q.idx == 3'd3 |-> cyc.data == st_q.ord.data)
		else $error("program data wrong");
	prog_cov: cover property (@(posedge core_clk_in) st_q.ord.op == OP_PROGRAM && st_q.done);
	erase_cov: cover property (@(posedge core_clk_in) st_q.ord.op == OP_SECT_ERS && st_q.done);
	poll_cov: cover property (@(posedge core_clk_in) st_q.ord.op == OP_POLL && st_q.idx == 3'd1 && st_q.done);
endmodule
`default_nettype wire
